// ===== hdl/gpcd_pkg.sv
// package with register map, field positions and reset values of the two pin ports
package gpcd_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] FIRST_PORT_DATA_OFS       = 8'h02;
  localparam logic [7:0] SECOND_PORT_DATA_OFS      = 8'h03;
  localparam logic [7:0] FIRST_PORT_DIRECTION_OFS  = 8'h06;
  localparam logic [7:0] SECOND_PORT_DIRECTION_OFS = 8'h07;

  // port widths
  localparam int FIRST_W  = 6;
  localparam int SECOND_W = 8;

  // field positions
  localparam int CLOCK_OUT_ENABLE_BIT = 7;
  localparam int CLOCK_OUT_PIN        = 2;
  localparam int TIMER_A_PIN          = 6;
  localparam int TIMER_B_PIN          = 4;
  localparam int CONVERTER_PINS       = 7;

  // converter channel number carried by second-port pin 0
  localparam logic [4:0] CONVERTER_CHANNEL_BASE = 5'h08;

  // prescaler code that picks the external timer clock
  localparam logic [2:0] PRESCALER_EXT_CLOCK = 3'h7;

  // reset values
  localparam logic [5:0] FIRST_DIRECTION_RESET  = 6'h00;
  localparam logic [7:0] SECOND_DIRECTION_RESET = 8'h00;
  localparam logic       CLOCK_OUT_RESET        = 1'h0;
  localparam logic [7:0] READ_DATA_RESET        = 8'h00;

endpackage

// ===== hdl/gpcd_ports.sv
// six-pin and eight-pin general-purpose ports with their data and direction registers
//
// What this block does
// - six bidirectional pins with writable data latches
// - first port latches keep value through reset
// - clock-out enable drives system clock on pin2
// - pin2 direction ignored while clock out enabled
// - clock-out enable is direction bit 7, reset clear
// - first port direction 1 drives, 0 floats
// - reset clears first port direction bits
// - first port read: latch if output, pin otherwise; pin2 reads zero while clock out enabled
// - writes always reach latch regardless of direction
// - eight second-port pins with latches and directions
// - second port latches keep value through reset
// - selected converter channel pin reads zero while its direction bit is clear
// - timer-used pins ignore direction for buffer
// - pins 6 and 4 feed timer external clocks
// - second port direction drives, reset clears all
// - second port read: latch if output, pin otherwise
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module gpcd_ports
  import gpcd_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  // register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                write_i,
  input  wire logic                read_i,
  output logic      [DATA_W-1:0]   rdata_o,
  // first port pins
  input  wire logic [FIRST_W-1:0]  first_port_pin_i,
  output logic      [FIRST_W-1:0]  first_port_pin_o,
  output logic      [FIRST_W-1:0]  first_port_pin_oe_o,
  // second port pins
  input  wire logic [SECOND_W-1:0] second_port_pin_i,
  output logic      [SECOND_W-1:0] second_port_pin_o,
  output logic      [SECOND_W-1:0] second_port_pin_oe_o,
  // shared converter and timer controls
  input  wire logic [4:0]          converter_channel_select_i,
  input  wire logic [2:0]          timer_a_prescaler_select_i,
  input  wire logic [2:0]          timer_b_prescaler_select_i,
  output logic                     timer_a_ext_clock_o,
  output logic                     timer_b_ext_clock_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // per bit: latch where the pin drives, pin level where it listens
  function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pin);
    read_mix = (dir & latch) | (~dir & pin);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [FIRST_W-1:0]  first_port_data;
  logic [FIRST_W-1:0]  first_port_direction;
  logic                clock_out_enable;
  logic [SECOND_W-1:0] second_port_data;
  logic [SECOND_W-1:0] second_port_direction;
  logic [FIRST_W-1:0]  first_sync_a;
  logic [FIRST_W-1:0]  first_sync;
  logic [SECOND_W-1:0] second_sync_a;
  logic [SECOND_W-1:0] second_sync;

  logic [FIRST_W-1:0]  next_first_port_data;
  logic [FIRST_W-1:0]  next_first_port_direction;
  logic                next_clock_out_enable;
  logic [SECOND_W-1:0] next_second_port_data;
  logic [SECOND_W-1:0] next_second_port_direction;
  logic [DATA_W-1:0]   next_rdata;

  // decoded pin uses
  logic                timer_a_uses_pin;
  logic                timer_b_uses_pin;
  logic [SECOND_W-1:0] converter_uses_pin;
  logic [SECOND_W-1:0] timer_uses_pin;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always_ff @(posedge clk_i) begin
    first_sync_a  <= first_port_pin_i;
    first_sync    <= first_sync_a;
    second_sync_a <= second_port_pin_i;
    second_sync   <= second_sync_a;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sharing decode

  assign timer_a_uses_pin = (timer_a_prescaler_select_i == PRESCALER_EXT_CLOCK);
  assign timer_b_uses_pin = (timer_b_prescaler_select_i == PRESCALER_EXT_CLOCK);

  // converter channel lands on one of pins 6..0
  always_comb begin
    converter_uses_pin = '0;
    for (int k = 0; k < CONVERTER_PINS; k++) begin
      if (converter_channel_select_i == CONVERTER_CHANNEL_BASE + 5'(k)) begin
        converter_uses_pin[k] = 1'b1;
      end
    end
  end

  always_comb begin
    timer_uses_pin              = '0;
    timer_uses_pin[TIMER_A_PIN] = timer_a_uses_pin;
    timer_uses_pin[TIMER_B_PIN] = timer_b_uses_pin;
  end

  // timer clocks taken from synchronised pins
  assign timer_a_ext_clock_o = timer_a_uses_pin & second_sync[TIMER_A_PIN];
  assign timer_b_ext_clock_o = timer_b_uses_pin & second_sync[TIMER_B_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // register writes and read data

  always_comb begin
    logic [7:0] mix;
    mix                        = '0;
    next_first_port_data       = first_port_data;
    next_second_port_data      = second_port_data;
    next_first_port_direction  = first_port_direction;
    next_clock_out_enable      = clock_out_enable;
    next_second_port_direction = second_port_direction;
    next_rdata                 = READ_DATA_RESET;
    if (write_i) begin
      if (addr_i == FIRST_PORT_DATA_OFS) begin
        // latch written whatever the direction; bits 7,6 dropped
        next_first_port_data = wdata_i[FIRST_W-1:0];
      end else if (addr_i == SECOND_PORT_DATA_OFS) begin
        next_second_port_data = wdata_i;
      end else if (addr_i == FIRST_PORT_DIRECTION_OFS) begin
        next_clock_out_enable     = wdata_i[CLOCK_OUT_ENABLE_BIT];
        next_first_port_direction = wdata_i[FIRST_W-1:0];
      end else if (addr_i == SECOND_PORT_DIRECTION_OFS) begin
        next_second_port_direction = wdata_i;
      end
    end
    if (read_i) begin
      if (addr_i == FIRST_PORT_DATA_OFS) begin
        // latch or pin per direction bit
        mix = read_mix({2'b00, first_port_direction}, {2'b00, first_port_data},
                       {2'b00, first_sync});
        // bit 2 reads zero while it carries the clock
        if (clock_out_enable) begin
          mix[CLOCK_OUT_PIN] = 1'b0;
        end
        next_rdata = {2'b00, mix[FIRST_W-1:0]};
      end else if (addr_i == SECOND_PORT_DATA_OFS) begin
        // latch or pin per direction bit
        mix = read_mix(second_port_direction, second_port_data, second_sync);
        // selected converter pin reads zero while its direction bit is clear
        mix = mix & ~(converter_uses_pin & ~second_port_direction);
        next_rdata = mix;
      end else if (addr_i == FIRST_PORT_DIRECTION_OFS) begin
        next_rdata = {clock_out_enable, 1'b0, first_port_direction};
      end else if (addr_i == SECOND_PORT_DIRECTION_OFS) begin
        next_rdata = second_port_direction;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    first_port_data  <= next_first_port_data;
    second_port_data <= next_second_port_data;
  end

  // first directions cleared; clock-out off; second cleared
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      first_port_direction  <= FIRST_DIRECTION_RESET;
      clock_out_enable      <= CLOCK_OUT_RESET;
      second_port_direction <= SECOND_DIRECTION_RESET;
      rdata_o               <= READ_DATA_RESET;
    end else begin
      first_port_direction  <= next_first_port_direction;
      clock_out_enable      <= next_clock_out_enable;
      second_port_direction <= next_second_port_direction;
      rdata_o               <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_comb begin
    first_port_pin_o    = first_port_data;
    first_port_pin_oe_o = first_port_direction;
    if (clock_out_enable) begin
      // system clock replaces latch on pin 2
      first_port_pin_o[CLOCK_OUT_PIN]    = clk_i;
      // pin 2 direction has no say
      first_port_pin_oe_o[CLOCK_OUT_PIN] = 1'b1;
    end
  end

  // direction drives; shared pins released to their user
  assign second_port_pin_o    = second_port_data;
  assign second_port_pin_oe_o = second_port_direction & ~timer_uses_pin & ~converter_uses_pin;

endmodule

// ===== verification/gpcd_chk.sv
// checker of register, buffer and timer pin behaviour of the pin ports
`timescale 1ns/1ps
module gpcd_chk
  import gpcd_pkg::*;
(
  // clock, reset and register port
  input wire logic                clk_i,
  input wire logic                resetn_i,
  input wire logic [ADDR_W-1:0]   addr_i,
  input wire logic [DATA_W-1:0]   wdata_i,
  input wire logic                write_i,
  input wire logic                read_i,
  input wire logic [DATA_W-1:0]   rdata_o,
  // pins and shared controls
  input wire logic [FIRST_W-1:0]  first_port_pin_o,
  input wire logic [FIRST_W-1:0]  first_port_pin_oe_o,
  input wire logic [SECOND_W-1:0] second_port_pin_o,
  input wire logic [SECOND_W-1:0] second_port_pin_oe_o,
  input wire logic [2:0]          timer_a_prescaler_select_i,
  input wire logic [2:0]          timer_b_prescaler_select_i,
  input wire logic                timer_a_ext_clock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // buffers and read data against their causes
  property p_rst; disable iff (1'b0) !resetn_i |=> !first_port_pin_oe_o && !second_port_pin_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("buffer on after reset");
  property p_dir; write_i && addr_i == 8'h06 && !wdata_i[7] |=> first_port_pin_oe_o == $past(wdata_i[5:0]); endproperty
  a_dir: assert property (p_dir) else $error("first buffer enable wrong");
  property p_cko; write_i && addr_i == 8'h06 && wdata_i[7] |=> first_port_pin_oe_o[2]; endproperty
  a_cko: assert property (p_cko) else $error("clock pin not driven");
  property p_clat; write_i && addr_i == 8'h02 |=> first_port_pin_o[1:0] == $past(wdata_i[1:0]); endproperty
  a_clat: assert property (p_clat) else $error("first latch not written");
  property p_dlat; write_i && addr_i == 8'h03 |=> second_port_pin_o == $past(wdata_i); endproperty
  a_dlat: assert property (p_dlat) else $error("second latch not written");
  property p_idle; !read_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_hi; read_i && addr_i == 8'h02 |=> rdata_o[7:6] == 2'h0; endproperty
  a_hi: assert property (p_hi) else $error("first data top bits set");
  property p_ta; timer_a_prescaler_select_i == 3'h7 |-> !second_port_pin_oe_o[6]; endproperty
  a_ta: assert property (p_ta) else $error("timer a pin driven");
  property p_tb; timer_b_prescaler_select_i == 3'h7 |-> !second_port_pin_oe_o[4]; endproperty
  a_tb: assert property (p_tb) else $error("timer b pin driven");
  property p_taoff; timer_a_prescaler_select_i != 3'h7 ##1 timer_a_prescaler_select_i != 3'h7 |-> !timer_a_ext_clock_o; endproperty
  a_taoff: assert property (p_taoff) else $error("timer a clock when unselected");
endmodule

bind gpcd_ports gpcd_chk gpcd_chk_inst (.*);

// ===== verification/gpcd_pins.sv
// external pin drivers: each pin follows the buffer when enabled, else the outside level
`timescale 1ns/1ps
module gpcd_pins (
  // buffers from the ports
  input  wire logic [5:0] c_o,
  input  wire logic [5:0] c_oe,
  input  wire logic [7:0] d_o,
  input  wire logic [7:0] d_oe,
  // outside level and resolved pins
  input  wire logic [7:0] ext_i,
  output logic      [5:0] c_i,
  output logic      [7:0] d_i
);
  // wire level from both drivers
  assign c_i = (c_oe & c_o) | (~c_oe & ext_i[5:0]);
  assign d_i = (d_oe & d_o) | (~d_oe & ext_i);
endmodule

// ===== verification/tb_gpcd_ports.sv
// testbench of the two pin ports
`timescale 1ns/1ps
module tb_gpcd_ports;
  import gpcd_pkg::*;
  logic       clk_i = 0, resetn_i = 0, write_i = 0, read_i = 0, pend = 0, ta, tbk;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, ext = 8'h00, d1, d2, rdata_o, pd_o, pd_oe, pd_i, q[$];
  logic [5:0] pc_o, pc_oe, pc_i;
  logic [4:0] csel = 5'h00;
  logic [2:0] psa = 3'h0, psb = 3'h0;
  int         err_total = 0, n_tests = 0, seed = 15;
  gpcd_ports gpcd_ports_inst (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .first_port_pin_i(pc_i), .first_port_pin_o(pc_o), .first_port_pin_oe_o(pc_oe),
    .second_port_pin_i(pd_i), .second_port_pin_o(pd_o), .second_port_pin_oe_o(pd_oe),
    .converter_channel_select_i(csel), .timer_a_prescaler_select_i(psa),
    .timer_b_prescaler_select_i(psb), .timer_a_ext_clock_o(ta), .timer_b_ext_clock_o(tbk));
  gpcd_pins gpcd_pins_inst (.c_o(pc_o), .c_oe(pc_oe), .d_o(pd_o), .d_oe(pd_oe),
    .ext_i(ext), .c_i(pc_i), .d_i(pd_i));
  // clock and watchdog
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a; read_i <= 1'b1; q.push_back(e);
    @(posedge clk_i);
    read_i <= 1'b0;
  endtask
  task automatic pins();
    ext <= 8'($random(seed));
    repeat (3) @(posedge clk_i);
  endtask
  // read data compared in the cycle after each read strobe
  always @(posedge clk_i) begin
    if (pend) chk("rdata", q.pop_front(), rdata_o);
    pend <= read_i;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    wr(8'h02, d1);
    wr(8'h03, d2);
    pins();
    rd(8'h02, {2'h0, ext[5:0]});
    rd(8'h03, ext);
    wr(8'h06, 8'h3f);
    wr(8'h07, 8'hff);
    rd(8'h02, {2'h0, d1[5:0]});
    rd(8'h03, d2);
    $display("test directions done");
    @(posedge clk_i) resetn_i <= 1'b0;
    @(posedge clk_i) resetn_i <= 1'b1;
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h3f);
    wr(8'h07, 8'hff);
    rd(8'h02, {2'h0, d1[5:0]});
    rd(8'h03, d2);
    $display("test reset keep done");
    wr(8'h07, 8'h00);
    for (int k = 0; k < 7; k++) begin
      csel <= 5'h08 + 5'(k);
      pins();
      rd(8'h03, ext & ~(8'h01 << k));
    end
    wr(8'h07, 8'hff);
    rd(8'h03, d2);
    csel <= 5'h00;
    psa <= 3'h7;
    psb <= 3'h7;
    pins();
    chk("timer_a", {7'h0, ext[6]}, {7'h0, ta});
    chk("timer_b", {7'h0, ext[4]}, {7'h0, tbk});
    rd(8'h03, d2);
    psa <= 3'h0;
    psb <= 3'h0;
    $display("test shared pins done");
    wr(8'h06, 8'hc0);
    rd(8'h06, 8'h80);
    #1 chk("clock_pin_hi", {7'h0, clk_i}, {7'h0, pc_o[2]});
    #50 chk("clock_pin_lo", {7'h0, clk_i}, {7'h0, pc_o[2]});
    rd(8'h02, {2'h0, ext[5:3], 1'b0, ext[1:0]});
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h02, 8'hff);
    wr(8'h06, 8'h3f);
    rd(8'h02, 8'h3f);
    $display("test clock out and unmapped done");
    repeat (2) @(posedge clk_i);
    close_out();
  end
endmodule
